// file: eba_pkg.sv
// eba_pkg: constants and carriers of the buffer access block.
// assumes a single clock; used by scope, never imported.
// Behaviour
// - buffer command returns pointer to first location
// - at most N+2 bytes per buffer command
// - pointer steps one byte or one word
// - DMA skips the two length bytes
// - DMA read flags last byte as end
// - external end of transfer sends partial buffer
// - code low nibble selects endpoint for buffers
// - length low, length high, then data bytes
// - 16-bit word pairs even byte low, odd high
// - DMA on double buffer moves to second buffer
// - status read clears endpoint interrupt bit
// - codes 50 to 5F read status byte
// - bit 7 stall, cleared by unstall or setup
// - bit 6 second full, bit 5 first full
// - bit 4 gives next data toggle
// - bit 3 setup clobbered, cleared on read
// - bit 2 setup held, bit 1 buffer select
package eba_pkg;
    localparam int EP_COUNT = 16;
    localparam int EP_W = 4;
    localparam int LEN_BYTES = 2;
    localparam int MAX_N_BULK = 32;
    localparam int MAX_N_ISO = 1023;
    localparam int BUF_BYTES = MAX_N_BULK + LEN_BYTES;
    localparam int PTR_W = 11;
    localparam int FIFO_DEPTH = 16;
    localparam logic [3:0] GRP_WR = 4'h0;
    localparam logic [3:0] GRP_RD = 4'h1;
    localparam logic [3:0] GRP_STALL = 4'h4;
    localparam logic [3:0] GRP_STAT = 4'h5;
    localparam logic [3:0] GRP_FILL = 4'h6;
    localparam logic [3:0] GRP_DRAIN = 4'h7;
    localparam logic [3:0] GRP_UNSTALL = 4'h8;
    localparam logic [3:0] GRP_CHECK = 4'hd;
    localparam logic [7:0] CMD_ACK = 8'hf4;
    localparam logic [3:0] EP_CTRL_OUT = 4'h0;
    localparam logic [3:0] EP_CTRL_IN = 4'h1;
    localparam int ST_HALT = 7;
    localparam int ST_FULL1 = 6;
    localparam int ST_FULL0 = 5;
    localparam int ST_TOGGLE = 4;
    localparam int ST_CLOB = 3;
    localparam int ST_SETUP = 2;
    localparam int ST_HOST_SIDE_BUFFER_SELECT = 1;
    localparam logic [7:0] STATE_RESET = 8'h00;

    typedef enum logic [2:0] {
        EBA_IDLE = 3'b000,
        EBA_WR = 3'b001,
        EBA_RD = 3'b011,
        EBA_STAT = 3'b010,
        EBA_CHECK = 3'b110
    } eba_mode_e;

    typedef struct packed {
        logic is_cmd;
        logic via_dma;
        logic [15:0] data;
    } eba_word_s;

    typedef struct packed {
        logic [EP_W-1:0] ep;
        logic setup_rx;
        logic setup_done;
        logic loaded;
        logic sent;
        logic buf_sel;
        logic toggle_flip;
        logic irq;
    } eba_usb_evt_s;

    typedef struct packed {
        logic [EP_W-1:0] ep;
        logic buf_sel;
        logic [PTR_W-1:0] addr;
    } eba_mem_ref_s;

    typedef struct packed {
        logic valid;
        logic [EP_W-1:0] ep;
        logic buf_sel;
        logic [PTR_W-1:0] count;
    } eba_send_s;
endpackage : eba_pkg

// file: eba_fifo.sv
// eba_fifo: flip-flop FIFO with valid/ready on both sides.
// assumes one clock and a sync reset.
module eba_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_r != '0;
    assign out_data_o = mem_r[rp_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
endmodule : eba_fifo

// file: eba_ep_state.sv
// eba_ep_state: status byte and interrupt bit of one endpoint.
// assumes one-cycle event pulses.
module eba_ep_state #(
    parameter bit DOUBLE = 1'b0
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic unstall_i,
    input wire logic setup_rx_i,
    input wire logic setup_done_i,
    input wire logic setup_ack_i,
    input wire logic loaded_i,
    input wire logic sent_i,
    input wire logic buf_i,
    input wire logic toggle_flip_i,
    input wire logic fill_i,
    input wire logic drain_i,
    input wire logic irq_evt_i,
    input wire logic stat_read_i,
    output logic [7:0] state_o,
    output logic irq_o
);
    logic halt_r, halt_nxt, tog_r, tog_nxt, clob_r, clob_nxt;
    logic held_r, held_nxt, cpu_r, cpu_nxt, irq_r, irq_nxt;
    logic acked_r, acked_nxt, busy_r, busy_nxt;
    logic [1:0] full_r, full_nxt;
    logic reinit;

    always_comb begin
        reinit = unstall_i | setup_rx_i;
        halt_nxt = stall_i | (halt_r & ~reinit);
        tog_nxt = reinit ? 1'b0 : tog_r ^ toggle_flip_i;
        full_nxt = unstall_i ? 2'b00 : full_r;
        if (sent_i) full_nxt[buf_i] = 1'b0;
        if (drain_i) full_nxt[cpu_r] = 1'b0;
        if (loaded_i) full_nxt[buf_i] = 1'b1;
        if (fill_i) full_nxt[cpu_r] = 1'b1;
        cpu_nxt = unstall_i ? 1'b0 : cpu_r ^ (DOUBLE & (fill_i | drain_i));
        held_nxt = setup_rx_i | (held_r & ~drain_i & ~unstall_i);
        acked_nxt = ~setup_rx_i & (acked_r | setup_ack_i);
        busy_nxt = setup_rx_i | (busy_r & ~setup_done_i);
        // set wins; clear waits for setup write end
        clob_nxt = (setup_rx_i & held_r & ~acked_r & ~halt_r)
            | (clob_r & ~(stat_read_i & ~busy_r));
        irq_nxt = irq_evt_i | (irq_r & ~stat_read_i);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            halt_r <= 1'b0;
            tog_r <= 1'b0;
            full_r <= 2'b00;
            cpu_r <= 1'b0;
            held_r <= 1'b0;
            acked_r <= 1'b0;
            busy_r <= 1'b0;
            clob_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            halt_r <= halt_nxt;
            tog_r <= tog_nxt;
            full_r <= full_nxt;
            cpu_r <= cpu_nxt;
            held_r <= held_nxt;
            acked_r <= acked_nxt;
            busy_r <= busy_nxt;
            clob_r <= clob_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign state_o = {halt_r, full_r[1], full_r[0], tog_r, clob_r, held_r, cpu_r, 1'b0};
    assign irq_o = irq_r;
endmodule : eba_ep_state

// file: eba_top.sv
// eba_top: endpoint buffer access over the parallel port and DMA.
// assumes a USB engine that loads and drains the buffers.
module eba_top #(
    parameter int BUF_BYTES = eba_pkg::BUF_BYTES,
    parameter logic [eba_pkg::EP_COUNT-1:0] DOUBLE_MASK = 16'hfffc
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic bus16_i,
    input wire logic command_data_select_i,
    input wire logic wr_i,
    output logic wr_ready_o,
    input wire logic rd_i,
    output logic rd_ready_o,
    input wire logic [15:0] wr_data_i,
    output logic [15:0] rd_data_o,
    input wire logic dma_active_i,
    input wire logic dma_dir_wr_i,
    input wire logic [eba_pkg::EP_W-1:0] dma_ep_i,
    input wire logic dma_wr_i,
    input wire logic dma_rd_i,
    input wire logic transfer_done_condition_i,
    output logic packet_end_condition_o,
    input wire eba_pkg::eba_usb_evt_s usb_evt_i,
    input wire logic usb_evt_valid_i,
    input wire logic usb_wr_i,
    input wire logic usb_rd_i,
    input wire eba_pkg::eba_mem_ref_s usb_ref_i,
    input wire logic [7:0] usb_wr_byte_i,
    output logic [7:0] usb_rd_byte_o,
    output eba_pkg::eba_send_s send_o,
    output logic [eba_pkg::EP_COUNT-1:0] irq_o
);
    localparam int NEP = eba_pkg::EP_COUNT;
    localparam int PW = eba_pkg::PTR_W;
    localparam int MEM_BYTES = NEP * 2 * BUF_BYTES;
    localparam int AW = $clog2(MEM_BYTES);
    localparam logic [PW-1:0] FIRST = PW'(eba_pkg::LEN_BYTES);
    localparam logic [PW-1:0] LAST = PW'(BUF_BYTES);

    ////////////////////////////////////////////////////////////////////////
    // storage and state
    logic [7:0] mem_r [MEM_BYTES];
    eba_pkg::eba_mode_e mode_r, mode_nxt;
    logic [eba_pkg::EP_W-1:0] sel_r, sel_nxt;
    logic [PW-1:0] ptr_r, ptr_nxt, dptr_r, dptr_nxt;
    logic don_r, don_nxt, eop_r, eop_nxt;
    logic [15:0] rdat_r, rdat_nxt;
    logic [7:0] ubyte_r, ubyte_nxt;
    eba_pkg::eba_send_s send_r, send_nxt;

    logic w0_en, w1_en;
    logic [AW-1:0] w0_a, w1_a, ra;
    logic [7:0] w0_d, w1_d;
    logic [NEP-1:0] stall_v, unstall_v, fill_v, drain_v, stat_v;
    logic ack;
    logic [7:0] state_v [NEP];
    logic [NEP-1:0] cpu_v;
    logic [PW-1:0] step, np;
    logic [7:0] code;
    logic [16:0] plen;

    eba_pkg::eba_word_s fin, fout;
    logic fin_valid, fout_valid, fout_ready, fifo_pop;

    function automatic logic [AW-1:0] slot(
        input logic [eba_pkg::EP_W-1:0] ep,
        input logic b,
        input logic [PW-1:0] p
    );
        slot = AW'(({ep, b} * BUF_BYTES) + p);
    endfunction : slot

    ////////////////////////////////////////////////////////////////////////
    // write stream: commands and data keep their order
    always_comb begin
        fin = '0;
        fin.is_cmd = command_data_select_i & wr_i;
        fin.via_dma = dma_wr_i;
        fin.data = wr_data_i;
        if (fin.is_cmd) fin.data[15:8] = 8'h00;
        fin_valid = wr_i | dma_wr_i;
    end

    // usb writes own the memory port, so the FIFO waits
    assign fout_ready = ~usb_wr_i;
    assign fifo_pop = fout_valid & fout_ready;

    eba_fifo #(
        .WIDTH($bits(eba_pkg::eba_word_s)),
        .DEPTH(eba_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(fin_valid),
        .in_ready_o(wr_ready_o),
        .in_data_i(fin),
        .out_valid_o(fout_valid),
        .out_ready_i(fout_ready),
        .out_data_o(fout)
    );

    // reads wait for queued writes, keeping order
    assign rd_ready_o = ~fout_valid;

    ////////////////////////////////////////////////////////////////////////
    // endpoint status
    for (genvar i = 0; i < NEP; i++) begin : g_ep
        logic hit;
        assign hit = usb_evt_valid_i & (usb_evt_i.ep == eba_pkg::EP_W'(i));
        eba_ep_state #(
            .DOUBLE(DOUBLE_MASK[i])
        ) u_state (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .stall_i(stall_v[i]),
            .unstall_i(unstall_v[i]),
            .setup_rx_i(hit & usb_evt_i.setup_rx),
            .setup_done_i(hit & usb_evt_i.setup_done),
            .setup_ack_i(ack),
            .loaded_i(hit & usb_evt_i.loaded),
            .sent_i(hit & usb_evt_i.sent),
            .buf_i(usb_evt_i.buf_sel),
            .toggle_flip_i(hit & usb_evt_i.toggle_flip),
            .fill_i(fill_v[i]),
            .drain_i(drain_v[i]),
            .irq_evt_i(hit & usb_evt_i.irq),
            .stat_read_i(stat_v[i]),
            .state_o(state_v[i]),
            .irq_o(irq_o[i])
        );
        assign cpu_v[i] = state_v[i][eba_pkg::ST_HOST_SIDE_BUFFER_SELECT];
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencing
    always_comb begin
        mode_nxt = mode_r;
        sel_nxt = sel_r;
        ptr_nxt = ptr_r;
        dptr_nxt = dptr_r;
        don_nxt = don_r & dma_active_i;
        rdat_nxt = rdat_r;
        eop_nxt = 1'b0;
        send_nxt = '0;
        ubyte_nxt = usb_rd_i ? mem_r[slot(usb_ref_i.ep, usb_ref_i.buf_sel, usb_ref_i.addr)] : ubyte_r;
        stall_v = '0;
        unstall_v = '0;
        fill_v = '0;
        drain_v = '0;
        stat_v = '0;
        ack = 1'b0;
        w0_en = 1'b0;
        w1_en = 1'b0;
        w0_a = '0;
        w1_a = '0;
        w0_d = 8'h00;
        w1_d = 8'h00;
        ra = '0;
        np = '0;
        plen = '0;
        code = fout.data[7:0];
        step = bus16_i ? PW'(2) : PW'(1);

        if (fifo_pop) begin
            if (fout.is_cmd) begin
                // low nibble is the endpoint
                unique case (code[7:4])
                    eba_pkg::GRP_WR: begin
                        if (code[3:0] != eba_pkg::EP_CTRL_OUT) begin
                            mode_nxt = eba_pkg::EBA_WR;
                            sel_nxt = code[3:0];
                            ptr_nxt = '0;
                        end
                    end
                    eba_pkg::GRP_RD: begin
                        if (code[3:0] != eba_pkg::EP_CTRL_IN) begin
                            mode_nxt = eba_pkg::EBA_RD;
                            sel_nxt = code[3:0];
                            ptr_nxt = '0;
                        end
                    end
                    eba_pkg::GRP_STAT: begin
                        mode_nxt = eba_pkg::EBA_STAT;
                        sel_nxt = code[3:0];
                    end
                    eba_pkg::GRP_CHECK: begin
                        mode_nxt = eba_pkg::EBA_CHECK;
                        sel_nxt = code[3:0];
                    end
                    eba_pkg::GRP_STALL: stall_v[code[3:0]] = 1'b1;
                    eba_pkg::GRP_UNSTALL: unstall_v[code[3:0]] = 1'b1;
                    eba_pkg::GRP_FILL: begin
                        if (code[3:0] != eba_pkg::EP_CTRL_OUT) begin
                            fill_v[code[3:0]] = 1'b1;
                            send_nxt = '{1'b1, code[3:0], cpu_v[code[3:0]], '0};
                        end
                    end
                    eba_pkg::GRP_DRAIN: begin
                        if (code[3:0] != eba_pkg::EP_CTRL_IN) drain_v[code[3:0]] = 1'b1;
                    end
                    default: ack = code == eba_pkg::CMD_ACK;
                endcase
            end else if (fout.via_dma) begin
                np = don_r ? dptr_r : FIRST;
                w0_en = 1'b1;
                w0_a = slot(dma_ep_i, cpu_v[dma_ep_i], np);
                w0_d = fout.data[7:0];
                w1_en = bus16_i;
                w1_a = w0_a + AW'(1);
                w1_d = fout.data[15:8];
                don_nxt = 1'b1;
                dptr_nxt = np + step;
                if (dptr_nxt >= LAST) begin
                    // full buffer ships; double buffers swap
                    fill_v[dma_ep_i] = 1'b1;
                    send_nxt = '{1'b1, dma_ep_i, cpu_v[dma_ep_i], LAST - FIRST};
                    dptr_nxt = FIRST;
                end
            end else if (mode_r == eba_pkg::EBA_WR) begin
                // low lane is the lower buffer byte
                w0_en = 1'b1;
                w0_a = slot(sel_r, cpu_v[sel_r], ptr_r);
                w0_d = fout.data[7:0];
                w1_en = bus16_i;
                w1_a = w0_a + AW'(1);
                w1_d = fout.data[15:8];
                ptr_nxt = ptr_r + step;
            end
        end

        if (rd_i & ~command_data_select_i & rd_ready_o) begin
            unique case (mode_r)
                eba_pkg::EBA_RD: begin
                    ra = slot(sel_r, cpu_v[sel_r], ptr_r);
                    rdat_nxt = {bus16_i ? mem_r[ra + AW'(1)] : 8'h00, mem_r[ra]};
                    ptr_nxt = ptr_r + step;
                end
                eba_pkg::EBA_STAT: begin
                    rdat_nxt = {8'h00, state_v[sel_r]};
                    stat_v[sel_r] = 1'b1;
                end
                eba_pkg::EBA_CHECK: rdat_nxt = {8'h00, state_v[sel_r]};
                default: rdat_nxt = 16'h0000;
            endcase
        end

        if (dma_rd_i & rd_ready_o) begin
            np = don_r ? dptr_r : FIRST;
            ra = slot(dma_ep_i, cpu_v[dma_ep_i], np);
            rdat_nxt = {bus16_i ? mem_r[ra + AW'(1)] : 8'h00, mem_r[ra]};
            plen = {1'b0, mem_r[slot(dma_ep_i, cpu_v[dma_ep_i], PW'(1))],
                mem_r[slot(dma_ep_i, cpu_v[dma_ep_i], '0)]} + 17'(eba_pkg::LEN_BYTES);
            eop_nxt = 17'(np + step) >= plen;
            don_nxt = 1'b1;
            dptr_nxt = np + step;
            if (eop_nxt | dptr_nxt >= LAST) begin
                drain_v[dma_ep_i] = 1'b1;
                dptr_nxt = FIRST;
            end
        end

        // external stop ships what is written so far
        if (transfer_done_condition_i & don_r & dma_dir_wr_i) begin
            fill_v[dma_ep_i] = 1'b1;
            send_nxt = '{1'b1, dma_ep_i, cpu_v[dma_ep_i], dptr_r - FIRST};
            dptr_nxt = FIRST;
            don_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_r <= eba_pkg::EBA_IDLE;
            sel_r <= '0;
            ptr_r <= '0;
            dptr_r <= FIRST;
            don_r <= 1'b0;
            rdat_r <= 16'h0000;
            eop_r <= 1'b0;
            send_r <= '0;
            ubyte_r <= 8'h00;
        end else begin
            mode_r <= mode_nxt;
            sel_r <= sel_nxt;
            ptr_r <= ptr_nxt;
            dptr_r <= dptr_nxt;
            don_r <= don_nxt;
            rdat_r <= rdat_nxt;
            eop_r <= eop_nxt;
            send_r <= send_nxt;
            ubyte_r <= ubyte_nxt;
        end
    end

    // no reset and no bounds check: the controller owns that
    always_ff @(posedge sys_clk_i) begin
        if (usb_wr_i) mem_r[slot(usb_ref_i.ep, usb_ref_i.buf_sel, usb_ref_i.addr)] <= usb_wr_byte_i;
        if (w0_en) mem_r[w0_a] <= w0_d;
        if (w1_en) mem_r[w1_a] <= w1_d;
    end

    assign rd_data_o = rdat_r;
    assign packet_end_condition_o = eop_r;
    assign send_o = send_r;
    assign usb_rd_byte_o = ubyte_r;
endmodule : eba_top

// file: eba_chk_assertions.sv
// eba_chk: port checks of eba_top, bound into it.
// assumes the clock and sync reset of eba_top.
module eba_chk #(
    parameter int BUF_BYTES = 34
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic bus16_i,
    input wire logic command_data_select_i,
    input wire logic wr_i,
    input wire logic wr_ready_o,
    input wire logic rd_i,
    input wire logic rd_ready_o,
    input wire logic [15:0] rd_data_o,
    input wire logic dma_wr_i,
    input wire logic dma_rd_i,
    input wire logic packet_end_condition_o,
    input wire logic usb_evt_valid_i,
    input wire eba_pkg::eba_send_s send_o,
    input wire logic [eba_pkg::EP_COUNT-1:0] irq_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence read_taken;
        (rd_i && !command_data_select_i || dma_rd_i) && rd_ready_o;
    endsequence
    sequence word_pushed;
        (wr_i || dma_wr_i) && wr_ready_o;
    endsequence
    ////////////////////////////////////////
    chk_reset_clean: assert property ($fell(rst_i) |-> rd_data_o == '0 && !packet_end_condition_o
        && send_o == '0 && irq_o == '0) else $error("outputs not reset");
    chk_read_holds: assert property (!((rd_i || dma_rd_i) && rd_ready_o) |=> $stable(rd_data_o))
        else $error("read data moved");
    chk_upper_lane_zero: assert property (!bus16_i ##0 read_taken |=> rd_data_o[15:8] == 8'h00)
        else $error("upper lane not zero");
    chk_eop_cause: assert property (packet_end_condition_o |-> $past(dma_rd_i && rd_ready_o))
        else $error("stray packet end");
    chk_push_blocks_read: assert property (word_pushed |=> !rd_ready_o)
        else $error("read ready while queued");
    chk_empty_not_full: assert property (rd_ready_o |-> wr_ready_o)
        else $error("empty and full");
    chk_irq_cause: assert property ((irq_o & ~$past(irq_o)) != '0 |-> $past(usb_evt_valid_i))
        else $error("stray interrupt");
    chk_send_bounded: assert property (send_o.valid |-> send_o.count <= 11'(BUF_BYTES - 2))
        else $error("send count too big");
    chk_send_pulse: assert property (send_o.valid |=> !send_o.valid || send_o != $past(send_o))
        else $error("send repeated");
endmodule : eba_chk

bind eba_top eba_chk #(.BUF_BYTES(BUF_BYTES)) u_eba_chk (.sys_clk_i, .rst_i, .bus16_i, .command_data_select_i,
    .wr_i, .wr_ready_o, .rd_i, .rd_ready_o, .rd_data_o, .dma_wr_i, .dma_rd_i, .packet_end_condition_o,
    .usb_evt_valid_i, .send_o, .irq_o);

// file: eba_usb_model.sv
// eba_usb_model: usb engine side of the buffers, loads and fetches bytes.
// assumes each fetched byte is registered a cycle later.
module eba_usb_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] rd_byte_i,
    output eba_pkg::eba_usb_evt_s evt_o,
    output logic evt_valid_o,
    output logic wr_o,
    output logic rd_o,
    output eba_pkg::eba_mem_ref_s ref_o,
    output logic [7:0] byte_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    initial begin
        evt_o = '0;
        evt_valid_o = 1'b0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        ref_o = '0;
        byte_o = 8'h00;
    end
    ////////////////////////////////////////
    task automatic event_pulse(input eba_pkg::eba_usb_evt_s e);
        evt_o <= e;
        evt_valid_o <= 1'b1;
        @(posedge sys_clk_i);
        evt_valid_o <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
    endtask : event_pulse
    // loaded event only after the whole packet lands
    task automatic load(input logic [3:0] ep, input logic [7:0] q[$]);
        foreach (q[i]) begin
            wr_o <= 1'b1;
            ref_o <= '{ep, 1'b0, 11'(i)};
            byte_o <= q[i];
            @(posedge sys_clk_i);
        end
        wr_o <= 1'b0;
        byte_o <= ~byte_o;
        event_pulse('{ep: ep, loaded: 1'b1, irq: 1'b1, default: 1'b0});
    endtask : load
    task automatic fetch(input logic [3:0] ep, input logic b, input int n);
        got.delete();
        for (int i = 0; i < n; i++) begin
            rd_o <= 1'b1;
            ref_o <= '{ep, b, 11'(i)};
            @(posedge sys_clk_i);
            rd_o <= 1'b0;
            @(posedge sys_clk_i);
            got.push_back(rd_byte_i);
        end
    endtask : fetch
endmodule : eba_usb_model

// file: tb.sv
// tb: self-checking bench for eba_top.
// assumes host and dma strobes on one 10 MHz clock.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, bus16_i = 1'b0, command_data_select_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic dma_active_i = 1'b0, dma_dir_wr_i = 1'b0, dma_wr_i = 1'b0, dma_rd_i = 1'b0, transfer_done_condition_i = 1'b0;
    logic [3:0] dma_ep_i = 4'h0;
    logic [15:0] wr_data_i = 16'h0000, rd_data_o, irq_o, d;
    logic wr_ready_o, rd_ready_o, packet_end_condition_o, usb_evt_valid_i, usb_wr_i, usb_rd_i, f;
    logic [7:0] usb_wr_byte_i, usb_rd_byte_o, q[$];
    eba_pkg::eba_usb_evt_s usb_evt_i;
    eba_pkg::eba_mem_ref_s usb_ref_i;
    eba_pkg::eba_send_s send_o, snd;
    int miscompares = 0, samples_checked = 0;
    int unsigned seed = 23;
    always #50 sys_clk_i = ~sys_clk_i;
    eba_top DUT (.sys_clk_i, .rst_i, .bus16_i, .command_data_select_i, .wr_i, .wr_ready_o, .rd_i, .rd_ready_o,
        .wr_data_i, .rd_data_o, .dma_active_i, .dma_dir_wr_i, .dma_ep_i, .dma_wr_i, .dma_rd_i,
        .transfer_done_condition_i, .packet_end_condition_o, .usb_evt_i, .usb_evt_valid_i, .usb_wr_i, .usb_rd_i,
        .usb_ref_i, .usb_wr_byte_i, .usb_rd_byte_o, .send_o, .irq_o);
    eba_usb_model u_usb (.sys_clk_i(sys_clk_i), .rd_byte_i(usb_rd_byte_o), .evt_o(usb_evt_i),
        .evt_valid_o(usb_evt_valid_i), .wr_o(usb_wr_i), .rd_o(usb_rd_i), .ref_o(usb_ref_i), .byte_o(usb_wr_byte_i));
    ////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic finish_test();
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
            miscompares++;
        end
    endtask : chk
    // 0 write ready, 1 read ready, 2 send pulse
    task automatic wait_hi(input int which);
        int n;
        logic r;
        for (n = 0; n < 200; n++) begin
            @(negedge sys_clk_i);
            r = which == 0 ? wr_ready_o : which == 1 ? rd_ready_o : send_o.valid;
            snd = send_o;
            @(posedge sys_clk_i);
            if (r === 1'b1) break;
        end
        if (n == 200) begin
            $display("mismatch at %0t: timeout", $time);
            miscompares++;
            finish_test();
        end
    endtask : wait_hi
    task automatic hw(input logic s, input logic [15:0] x, input bit dma = 1'b0);
        command_data_select_i <= s;
        wr_data_i <= x;
        dma_wr_i <= dma;
        wr_i <= !dma;
        wait_hi(0);
        wr_i <= 1'b0;
        dma_wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : hw
    task automatic hr(output logic [15:0] x, output logic e, input bit dma = 1'b0);
        command_data_select_i <= 1'b0;
        dma_rd_i <= dma;
        rd_i <= !dma;
        wait_hi(1);
        rd_i <= 1'b0;
        dma_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        x = rd_data_o;
        e = packet_end_condition_o;
        @(posedge sys_clk_i);
    endtask : hr
    task automatic st(input logic [3:0] e, input logic [7:0] x);
        hw(1'b1, {8'h00, eba_pkg::GRP_STAT, e});
        hr(d, f);
        chk(d, {8'h00, x});
    endtask : st
    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        for (int e = 0; e < 16; e++) st(4'(e), 8'h00);
        $display("test status_reset done");
        for (int e = 0; e < 16; e++) begin
            bus16_i <= e[0];
            q = {8'h06, 8'h00};
            repeat (6) q.push_back(rnd());
            if (e != 0) begin
                hw(1'b1, {8'h00, eba_pkg::GRP_WR, 4'(e)});
                hw(1'b0, 16'h5a5a);
                hw(1'b1, {8'h00, eba_pkg::GRP_WR, 4'(e)});
                for (int i = 0; i < 8; i += 1 + e[0]) hw(1'b0, {e[0] ? q[i + 1] : 8'h00, q[i]});
                u_usb.fetch(4'(e), 1'b0, 8);
                foreach (q[i]) chk({8'h00, u_usb.got[i]}, {8'h00, q[i]});
            end
            if (e != 1) begin
                u_usb.load(4'(e), q);
                chk(16'(irq_o[e]), 16'h0001);
                hw(1'b1, {8'h00, eba_pkg::GRP_RD, 4'(e)});
                for (int i = 0; i < 8; i += 1 + e[0]) begin
                    hr(d, f);
                    chk(d, e[0] ? {q[i + 1], q[i]} : {8'h00, q[i]});
                end
                st(4'(e), 8'h20);
                chk(16'(irq_o[e]), 16'h0000);
            end
        end
        $display("test buffer_access done");
        hw(1'b1, {8'h00, eba_pkg::GRP_STALL, 4'h4});
        st(4'h4, 8'ha0);
        u_usb.event_pulse('{ep: 4'h4, toggle_flip: 1'b1, default: 1'b0});
        st(4'h4, 8'hb0);
        hw(1'b1, {8'h00, eba_pkg::GRP_UNSTALL, 4'h4});
        st(4'h4, 8'h00);
        hw(1'b1, {8'h00, eba_pkg::GRP_STALL, 4'h0});
        u_usb.event_pulse('{ep: 4'h0, setup_rx: 1'b1, default: 1'b0});
        st(4'h0, 8'h24);
        $display("test status_bits done");
        bus16_i <= 1'b0;
        dma_ep_i <= 4'h5;
        dma_dir_wr_i <= 1'b1;
        dma_active_i <= 1'b1;
        q = {rnd(), rnd(), rnd()};
        foreach (q[i]) hw(1'b0, {8'h00, q[i]}, 1'b1);
        repeat (3) @(posedge sys_clk_i);
        transfer_done_condition_i <= 1'b1;
        @(posedge sys_clk_i);
        transfer_done_condition_i <= 1'b0;
        wait_hi(2);
        chk({5'h00, snd.count}, 16'h0003);
        u_usb.fetch(4'h5, snd.buf_sel, 5);
        foreach (q[i]) chk({8'h00, u_usb.got[i + 2]}, {8'h00, q[i]});
        dma_active_i <= 1'b0;
        q = {8'h04, 8'h00, rnd(), rnd(), rnd(), rnd()};
        u_usb.load(4'h6, q);
        dma_ep_i <= 4'h6;
        dma_dir_wr_i <= 1'b0;
        dma_active_i <= 1'b1;
        @(posedge sys_clk_i);
        for (int i = 2; i < 6; i++) begin
            hr(d, f, 1'b1);
            chk(d, {8'h00, q[i]});
            chk(16'(f), 16'(i == 5));
        end
        $display("test dma done");
        finish_test();
    end
endmodule : tb
